// >>> rtl/tmr_presc.sv
// Prescaler producing one-cycle source ticks for both channels
module tmr_presc
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Selects and ticks
  tmr_tick_if.presc bus
);

  logic [tmr_pkg::PRE_W-1:0] pre_ff;
  logic [tmr_pkg::FS_DIV_W-1:0] fs_div_ff;

  // Free-running divider of the system clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_ff <= '0;
    else
      pre_ff <= pre_ff + 11'h001;
  end

  // Low-frequency edges divided by eight for the slow select
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      fs_div_ff <= '0;
    else if (bus.fs_rise)
      fs_div_ff <= fs_div_ff + 3'h1;
  end

  function automatic logic tick_of(input logic [2:0] sel);
    logic t;
    t = 1'b0;
    case (sel)
      tmr_pkg::CKS_SLOW:
        t = bus.slow_sel ? (bus.fs_rise && (&fs_div_ff)) : (&pre_ff);
      tmr_pkg::CKS_DIV7: t = &pre_ff[6:0];
      tmr_pkg::CKS_DIV5: t = &pre_ff[4:0];
      tmr_pkg::CKS_DIV3: t = &pre_ff[2:0];
      tmr_pkg::CKS_FS: t = bus.fs_rise;
      tmr_pkg::CKS_DIV1: t = pre_ff[0];
      tmr_pkg::CKS_FC: t = 1'b1;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Procedural so the counters read inside the function keep the ticks fresh
  always_comb
  begin
    bus.tick[0] = tick_of(bus.sel_lo);
    bus.tick[1] = tick_of(bus.sel_hi);
  end

endmodule

// >>> rtl/tmr_top.sv
// Two 8-bit timer channels with divider, PWM and cascaded 16-bit timer modes
//
// How it works
// - Divider mode gives a 50% square wave, half period set by match value.
// - Divider mode counts source ticks; on match the flop toggles and counter clears.
// - Divider match also raises the channel match interrupt.
// - Divider pin always shows the inverse of the output flop.
// - Output flop loads from the control flop bit, cleared to 0 at reset.
// - Match register is unbuffered; writes hit the compare at once.
// - Stopping freezes the pin; flop bit writable only once already stopped.
// - PWM toggles on duty match, toggles back on overflow with interrupt.
// - PWM pin is the inverse of the flop; initial value picks polarity.
// - Duty is staged while running, moved to active at interrupt event.
// - Duty read shows the active value until the next interrupt event.
// - Cascaded mode runs on upper run bit, matches 16 bits, interrupts upper.
// - Cascaded mode takes its source clock from the lower clock select.
module tmr_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [tmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tmr_pkg::DATA_W-1:0] reg_rdata,
  // Clock source pins
  input wire logic low_freq_clock,
  input wire logic slow_prescale_select,
  // Channel outputs, index 0 lower, 1 upper
  output logic [1:0] divider_out_pin,
  output logic [1:0] duty_out_pin,
  output logic [1:0] match_irq
);

  // ********************************
  // Reset and pin synchronisers
  // ********************************
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [1:0] fs_sync_ff;
  logic fs_last_ff;
  logic [1:0] slow_sync_ff;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  assign rst_n = rst_sync_ff[1];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fs_sync_ff <= 2'h0;
      fs_last_ff <= 1'b0;
      slow_sync_ff <= 2'h0;
    end
    else
    begin
      fs_sync_ff <= {fs_sync_ff[0], low_freq_clock};
      fs_last_ff <= fs_sync_ff[1];
      slow_sync_ff <= {slow_sync_ff[0], slow_prescale_select};
    end
  end

  // ********************************
  // Register state
  // ********************************
  logic [7:0] ctrl_ff [2];
  logic [7:0] match_ff [2];
  logic [7:0] stage_ff [2];
  logic [7:0] active_ff [2];
  logic [7:0] cnt_ff [2];
  logic [7:0] nxt_cnt [2];
  logic [1:0] out_inv_ff;
  logic [1:0] nxt_out_inv;
  logic [1:0] irq_ff;
  logic [1:0] nxt_irq;
  logic [1:0] xfer;
  logic [1:0] run;
  logic [1:0] pwm_run;
  logic [2:0] mode [2];
  logic cascade;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [15:0] cnt16;
  logic [15:0] inc16;

  tmr_tick_if tick_bus ();

  function automatic logic [7:0] inc8(input logic [7:0] v);
    return v + 8'h01;
  endfunction

  function automatic logic wr_hit(input logic [3:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      mode[i] = ctrl_ff[i][tmr_pkg::CTRL_MODE_LSB +: 3];
      run[i] = ctrl_ff[i][tmr_pkg::CTRL_RUN_BIT];
    end
    cascade = (mode[1] == tmr_pkg::MODE_T16);
    pwm_run[0] = run[0] && (mode[0] == tmr_pkg::MODE_PWM) && !cascade;
    pwm_run[1] = run[1] && (mode[1] == tmr_pkg::MODE_PWM);
  end

  // ********************************
  // Prescaler
  // ********************************
  // lower select
  assign tick_bus.sel_lo = ctrl_ff[0][tmr_pkg::CTRL_CKS_LSB +: 3];
  assign tick_bus.sel_hi = ctrl_ff[1][tmr_pkg::CTRL_CKS_LSB +: 3];
  assign tick_bus.slow_sel = slow_sync_ff[1];
  assign tick_bus.fs_rise = fs_sync_ff[1] && !fs_last_ff;

  tmr_presc u_presc
  (
    .clk(clk),
    .rst_n(rst_n),
    .bus(tick_bus)
  );

  // ********************************
  // Control and match registers
  // ********************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff[0] <= tmr_pkg::CTRL_RST;
      ctrl_ff[1] <= tmr_pkg::CTRL_RST;
    end
    else
    begin
      if (wr_hit(tmr_pkg::OFS_CTRL_LO))
        ctrl_ff[0] <= reg_wdata;
      if (wr_hit(tmr_pkg::OFS_CTRL_HI))
        ctrl_ff[1] <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      match_ff[0] <= tmr_pkg::MATCH_RST;
      match_ff[1] <= tmr_pkg::MATCH_RST;
    end
    else
    begin
      if (wr_hit(tmr_pkg::OFS_MATCH_LO))
        match_ff[0] <= reg_wdata;
      if (wr_hit(tmr_pkg::OFS_MATCH_HI))
        match_ff[1] <= reg_wdata;
    end
  end

  // ********************************
  // Duty double buffer
  // ********************************
  // staged duty
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_ff[0] <= tmr_pkg::DUTY_RST;
      stage_ff[1] <= tmr_pkg::DUTY_RST;
      active_ff[0] <= tmr_pkg::DUTY_RST;
      active_ff[1] <= tmr_pkg::DUTY_RST;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        // coincident write moves the old stage
        if (xfer[i])
          active_ff[i] <= stage_ff[i];
        else if (wr_hit(i[0] ? tmr_pkg::OFS_DUTY_HI : tmr_pkg::OFS_DUTY_LO) && !pwm_run[i])
          active_ff[i] <= reg_wdata;
        if (wr_hit(i[0] ? tmr_pkg::OFS_DUTY_HI : tmr_pkg::OFS_DUTY_LO))
          stage_ff[i] <= reg_wdata;
      end
    end
  end

  // ********************************
  // Counters and output flops
  // ********************************
  always_comb
  begin
    nxt_cnt[0] = cnt_ff[0];
    nxt_cnt[1] = cnt_ff[1];
    nxt_out_inv = out_inv_ff;
    nxt_irq = 2'h0;
    xfer = 2'h0;
    cnt16 = {cnt_ff[1], cnt_ff[0]};
    inc16 = cnt16 + 16'h0001;
    if (cascade)
    begin
      if (!run[1])
      begin
        nxt_cnt[0] = tmr_pkg::COUNT_RST;
        nxt_cnt[1] = tmr_pkg::COUNT_RST;
      end
      else if (tick_bus.tick[0])
      begin
        if (inc16 == {match_ff[1], match_ff[0]})
        begin
          nxt_cnt[0] = tmr_pkg::COUNT_RST;
          nxt_cnt[1] = tmr_pkg::COUNT_RST;
          nxt_irq[1] = 1'b1;
        end
        else
        begin
          nxt_cnt[0] = inc16[7:0];
          nxt_cnt[1] = inc16[15:8];
        end
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!run[i])
          nxt_cnt[i] = tmr_pkg::COUNT_RST;
        else if (tick_bus.tick[i])
        begin
          case (mode[i])
            tmr_pkg::MODE_PDO:
            begin
              if (inc8(cnt_ff[i]) == match_ff[i])
              begin
                nxt_cnt[i] = tmr_pkg::COUNT_RST;
                nxt_out_inv[i] = !out_inv_ff[i];
                nxt_irq[i] = 1'b1;
              end
              else
                nxt_cnt[i] = inc8(cnt_ff[i]);
            end
            tmr_pkg::MODE_PWM:
            begin
              if (cnt_ff[i] == tmr_pkg::COUNT_TOP)
              begin
                nxt_cnt[i] = tmr_pkg::COUNT_RST;
                nxt_out_inv[i] = !out_inv_ff[i];
                nxt_irq[i] = 1'b1;
                xfer[i] = 1'b1;
              end
              else
              begin
                nxt_cnt[i] = inc8(cnt_ff[i]);
                if (inc8(cnt_ff[i]) == active_ff[i])
                  nxt_out_inv[i] = !out_inv_ff[i];
              end
            end
            tmr_pkg::MODE_TIMER8:
            begin
              if (inc8(cnt_ff[i]) == match_ff[i])
              begin
                nxt_cnt[i] = tmr_pkg::COUNT_RST;
                nxt_irq[i] = 1'b1;
              end
              else
                nxt_cnt[i] = inc8(cnt_ff[i]);
            end
            default:
              nxt_cnt[i] = cnt_ff[i];
          endcase
        end
      end
    end
    // flop loads only while already stopped
    for (int i = 0; i < 2; i++)
    begin
      if (wr_hit(i[0] ? tmr_pkg::OFS_CTRL_HI : tmr_pkg::OFS_CTRL_LO) && !run[i])
        nxt_out_inv[i] = !reg_wdata[tmr_pkg::CTRL_FF_BIT];
    end
  end

  // Stored inverted so each pin is a flop; reset flop 0 shows pin high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff[0] <= tmr_pkg::COUNT_RST;
      cnt_ff[1] <= tmr_pkg::COUNT_RST;
      out_inv_ff <= 2'h3;
      irq_ff <= 2'h0;
    end
    else
    begin
      cnt_ff[0] <= nxt_cnt[0];
      cnt_ff[1] <= nxt_cnt[1];
      out_inv_ff <= nxt_out_inv;
      irq_ff <= nxt_irq;
    end
  end

  assign divider_out_pin = out_inv_ff;
  assign duty_out_pin = out_inv_ff;
  assign match_irq = irq_ff;

  // ********************************
  // Read port
  // ********************************
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        tmr_pkg::OFS_CTRL_LO: nxt_rdata = ctrl_ff[0];
        tmr_pkg::OFS_CTRL_HI: nxt_rdata = ctrl_ff[1];
        tmr_pkg::OFS_MATCH_LO: nxt_rdata = match_ff[0];
        tmr_pkg::OFS_MATCH_HI: nxt_rdata = match_ff[1];
        tmr_pkg::OFS_DUTY_LO: nxt_rdata = active_ff[0];
        tmr_pkg::OFS_DUTY_HI: nxt_rdata = active_ff[1];
        tmr_pkg::OFS_COUNT_LO: nxt_rdata = cnt_ff[0];
        tmr_pkg::OFS_COUNT_HI: nxt_rdata = cnt_ff[1];
        tmr_pkg::OFS_STATUS: nxt_rdata = {4'h0, cascade, 1'b0, ~out_inv_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= nxt_rdata;
  end

  assign reg_rdata = rdata_ff;

endmodule

// >>> shared/tmr_pkg.sv
// Constants, register map and field layout of the cascadable timer
package tmr_pkg;

  // ********************************
  // Register bus
  // ********************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [3:0] OFS_CTRL_LO = 4'h0;
  localparam logic [3:0] OFS_CTRL_HI = 4'h1;
  localparam logic [3:0] OFS_MATCH_LO = 4'h2;
  localparam logic [3:0] OFS_MATCH_HI = 4'h3;
  localparam logic [3:0] OFS_DUTY_LO = 4'h4;
  localparam logic [3:0] OFS_DUTY_HI = 4'h5;
  localparam logic [3:0] OFS_COUNT_LO = 4'h6;
  localparam logic [3:0] OFS_COUNT_HI = 4'h7;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // ********************************
  // Control register fields
  // ********************************
  localparam int CTRL_FF_BIT = 7;
  localparam int CTRL_CKS_LSB = 4;
  localparam int CTRL_RUN_BIT = 3;
  localparam int CTRL_MODE_LSB = 0;

  localparam logic [2:0] MODE_TIMER8 = 3'h0;
  localparam logic [2:0] MODE_PDO = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_T16 = 3'h4;

  localparam logic [2:0] CKS_SLOW = 3'h0;
  localparam logic [2:0] CKS_DIV7 = 3'h1;
  localparam logic [2:0] CKS_DIV5 = 3'h2;
  localparam logic [2:0] CKS_DIV3 = 3'h3;
  localparam logic [2:0] CKS_FS = 3'h4;
  localparam logic [2:0] CKS_DIV1 = 3'h5;
  localparam logic [2:0] CKS_FC = 3'h6;

  // ********************************
  // Prescaler and reset values
  // ********************************
  localparam int PRE_W = 11;
  localparam int FS_DIV_W = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;

endpackage

// >>> shared/tmr_tick_if.sv
// Clock selects and source ticks between the timer core and its prescaler
interface tmr_tick_if;
  logic [2:0] sel_lo;
  logic [2:0] sel_hi;
  logic slow_sel;
  logic fs_rise;
  logic [1:0] tick;

  modport core
  (
    output sel_lo,
    output sel_hi,
    output slow_sel,
    output fs_rise,
    input tick
  );

  modport presc
  (
    input sel_lo,
    input sel_hi,
    input slow_sel,
    input fs_rise,
    output tick
  );
endinterface

// >>> testbench/tb.sv
// Self-checking bench for the cascadable timer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] dpin;
  logic [1:0] wpin;
  logic [1:0] irq;
  logic p;
  logic lfc = 1'b0;
  logic slow = 1'b0;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int t0;
  int t1;

  tmr_top tmr_top_inst
  (
    .clk(clk),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .low_freq_clock(lfc),
    .slow_prescale_select(slow),
    .divider_out_pin(dpin),
    .duty_out_pin(wpin),
    .match_irq(irq)
  );

  always #5 clk = ~clk;

  // Hang guard, far above the few thousand cycles needed
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // Low-frequency pin: one rising edge every 16 cycles
    lfc <= cyc[3];
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end

  // ****
  // Shared tasks
  // ****
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s exp %0h got %0h", what, exp, got);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rchk(string what, logic [3:0] a, logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, exp, reg_rdata);
  endtask

  // Stamp of the next lower or upper match pulse
  task automatic wirq(int ch, output int t);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (irq[ch] !== 1'b1 && n < 1000);
    chk("irq seen", 16'h1, n < 1000);
    t = cyc;
  endtask

  // Cycles at the post-overflow level over one period
  task automatic pwm_meas(logic [7:0] duty);
    int n;
    n = 0;
    wirq(0, t0);
    p = dpin[0];
    chk("polarity", 16'h1, p);
    chk("duty pin", p, wpin[0]);
    repeat (256)
    begin
      if (dpin[0] === p)
        n++;
      @(negedge clk);
    end
    chk("pwm irq", 16'h1, irq[0]);
    chk("duty width", duty, n);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    @(negedge clk);
    chk("pins", 16'h3, dpin);
    rchk("ctrl", 4'h0, 8'h00);
    rchk("match", 4'h2, 8'h00);
    rchk("duty", 4'h4, 8'h00);
    rchk("unmapped", 4'h9, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_pdo();
    wr(4'h2, 8'h03);
    wr(4'h0, 8'h69);
    wirq(0, t0);
    p = dpin[0];
    wirq(0, t1);
    chk("half period", 16'h3, t1 - t0);
    chk("toggle", !p, dpin[0]);
    wr(4'h2, 8'h06);
    wirq(0, t0);
    chk("new match", 16'h6, t0 - t1);
    wr(4'h0, 8'h61);
    @(negedge clk);
    p = dpin[0];
    repeat (6) @(negedge clk);
    chk("frozen", p, dpin[0]);
    wr(4'h0, 8'hE1);
    @(negedge clk);
    chk("ff set", 16'h0, dpin[0]);
    rchk("status", 4'h8, 8'h01);
    $display("divider test done");
  endtask

  task automatic t_presc();
    wr(4'h2, 8'h02);
    wr(4'h0, 8'h39);
    wirq(0, t0);
    wirq(0, t1);
    chk("sys/8 half period", 16'h0010, t1 - t0);
    wr(4'h0, 8'h31);
    wr(4'h0, 8'h49);
    wirq(0, t0);
    wirq(0, t1);
    chk("low clock half period", 16'h0020, t1 - t0);
    wr(4'h0, 8'h41);
    slow <= 1'b1;
    wr(4'h0, 8'h09);
    wirq(0, t0);
    wirq(0, t1);
    chk("slow half period", 16'h0100, t1 - t0);
    wr(4'h0, 8'h01);
    slow <= 1'b0;
    $display("prescaler test done");
  endtask

  task automatic t_pwm();
    wr(4'h4, 8'h10);
    rchk("duty stopped", 4'h4, 8'h10);
    wr(4'h0, 8'h6A);
    pwm_meas(8'h10);
    wr(4'h4, 8'h20);
    rchk("duty staged", 4'h4, 8'h10);
    wirq(0, t0);
    rchk("duty moved", 4'h4, 8'h20);
    pwm_meas(8'h20);
    // Stop, then keep the control bus quiet while the pin is frozen
    wr(4'h0, 8'h62);
    repeat (5) @(posedge clk);
    $display("pwm test done");
  endtask

  task automatic t_casc();
    wr(4'h2, 8'h2C);
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h60);
    // Upper select set to none: only the lower select may clock it
    wr(4'h1, 8'h74);
    wr(4'h1, 8'h7C);
    wirq(1, t0);
    wirq(1, t1);
    chk("16-bit interval", 16'h012C, t1 - t0);
    rchk("status cascade", 4'h8, 8'h08);
    wr(4'h1, 8'h74);
    $display("cascade test done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_pdo();
    t_presc();
    t_pwm();
    t_casc();
    summarize();
  end
endmodule

// >>> testbench/tmr_monitor.sv
// Port-level assertion checker for the timer top
module tmr_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Channel outputs
  input wire logic [1:0] divider_out_pin,
  input wire logic [1:0] duty_out_pin,
  input wire logic [1:0] match_irq
);
  // ****
  // Shadow of the control writes
  // ****
  logic [7:0] c0_ff;
  logic [7:0] c1_ff;
  logic run0;
  logic pdo0;
  logic pwm0;
  logic casc;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      c0_ff <= 8'h00;
      c1_ff <= 8'h00;
    end
    else if (reg_wr && reg_addr == 4'h0)
      c0_ff <= reg_wdata;
    else if (reg_wr && reg_addr == 4'h1)
      c1_ff <= reg_wdata;
  end

  assign run0 = c0_ff[tmr_pkg::CTRL_RUN_BIT];
  assign pdo0 = c0_ff[2:0] == tmr_pkg::MODE_PDO;
  assign pwm0 = c0_ff[2:0] == tmr_pkg::MODE_PWM;
  assign casc = c1_ff[2:0] == tmr_pkg::MODE_T16;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence stop_req;
    reg_wr && reg_addr == 4'h0 && run0 && !reg_wdata[3];
  endsequence

  // ****
  // Assertions
  // ****
  pins_same_a: assert property (duty_out_pin == divider_out_pin)
    else $error("duty and divider pins differ");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  reset_idle_a: assert property ($rose(nrst) |->
    (divider_out_pin == 2'h3 && match_irq == 2'h0)[*3])
    else $error("outputs not idle after reset");
  pdo_sync_a: assert property ($past(run0, 2) && run0 && pdo0 |->
    $changed(divider_out_pin[0]) == match_irq[0])
    else $error("divider toggle and irq apart");
  ff_load_a: assert property (reg_wr && reg_addr == 4'h0 && !run0 |=>
    divider_out_pin[0] == !$past(reg_wdata[7]))
    else $error("flop not loaded while stopped");
  stop_hold_a: assert property (stop_req |=> $stable(divider_out_pin[0])[*4])
    else $error("pin moved after stop");
  casc_irq_a: assert property (casc |-> !match_irq[0])
    else $error("lower irq in cascade");
  pwm_period_a: assert property (pwm0 && run0 && c0_ff[6:4] == 3'h6 &&
    match_irq[0] |-> ##256 (match_irq[0] || !run0))
    else $error("pwm period not 256");
endmodule

bind tmr_top tmr_monitor tmr_monitor_inst
(
  .clk(clk),
  .nrst(nrst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .divider_out_pin(divider_out_pin),
  .duty_out_pin(duty_out_pin),
  .match_irq(match_irq)
);
